// ### core/spi_byte_fifo.sv
`timescale 1ns/1ps
module spi_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int LW = $clog2(DEPTH)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic push,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic pop,
    output logic [WIDTH-1:0] rdata,
    output logic [LW:0] level,
    output logic full,
    output logic empty
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [LW-1:0] wr_ptr;
    logic [LW-1:0] rd_ptr;
    logic do_push;
    logic do_pop;

    // Overflow and underflow are dropped, never wrapped
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign full = level == (LW+1)'(DEPTH);
    assign empty = level == '0;
    assign rdata = mem[rd_ptr];

    // Pointers and fill level; clear beats a same-cycle push
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else if (clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (do_push) wr_ptr <= wr_ptr + 1'b1;
            if (do_pop) rd_ptr <= rd_ptr + 1'b1;
            if (do_push && !do_pop) level <= level + 1'b1;
            else if (do_pop && !do_push) level <= level - 1'b1;
        end
    end

    // Storage needs no reset
    always_ff @(posedge pclk) begin
        if (do_push && !clear) mem[wr_ptr] <= wdata;
    end
endmodule

// ### core/spi_byte_if.sv
`timescale 1ns/1ps
interface spi_byte_if;
    logic start;
    spi_master_pkg::byte_t tx_byte;
    logic idle;
    logic rx_valid;
    spi_master_pkg::byte_t rx_byte;
    logic idle_level;
    logic sample_phase;
    logic [15:0] half_period;
    logic low_speed;
    logic [3:0] hold;
    modport ctrl(output start, tx_byte, idle_level, sample_phase, half_period, low_speed,
        hold, input idle, rx_valid, rx_byte);
    modport eng(input start, tx_byte, idle_level, sample_phase, half_period, low_speed,
        hold, output idle, rx_valid, rx_byte);
endinterface

// ### core/spi_master_defs.svh
`ifndef SPI_MASTER_DEFS_SVH
`define SPI_MASTER_DEFS_SVH
// Register byte addresses
`define OFS_CONTROL 8'h00
`define OFS_DATA 8'h04
`define OFS_CLOCK_DIV 8'h08
`define OFS_BYTE_COUNT 8'h0c
`define OFS_HOLD 8'h10
`define OFS_THRESH 8'h14
// Control and status fields
`define B_CHIP_SEL 1:0
`define B_PHASE 2
`define B_IDLE_LEVEL 3
`define B_CLEAR_TX 4
`define B_CLEAR_RX 5
`define B_ACTIVE 7
`define B_DMA_EN 8
`define B_IRQ_DONE 9
`define B_IRQ_RX 10
`define B_AUTO_REL 11
`define B_LOW_SPEED 13
`define B_DONE 16
`define B_RX_NEEDS 17
`define B_TX_SPACE 18
`define B_RX_DATA 19
`define B_RX_FULL 20
`define F_SETTINGS 7:0
`define F_WORD_COUNT 31:16
`define F_COUNT 15:0
`define F_HOLD 3:0
`define F_RX_URGENT 31:24
`define F_RX_REQ 23:16
`define F_TX_URGENT 15:8
`define F_TX_REQ 7:0
// Reset values
`define RST_HOLD 4'h1
`define RST_RX_URGENT 8'h30
`define RST_RX_REQ 8'h20
`define RST_TX_URGENT 8'h10
`define RST_TX_REQ 8'h20
// Timing in core clocks, then the last serial clock edge and the last byte lane
`define CS_SETUP_CYCLES 2'h3
`define HALF_AT_ZERO 16'h8000
`define LAST_EDGE 4'hf
`define LAST_LANE 2'h3
`endif

// ### core/spi_master_dma.sv
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "spi_master_defs.svh"
// Overview of operation
// R1 - Sixteen-bit byte count sets DMA length
// R2 - Byte count matters only in DMA mode
// R3 - Low-speed link holds outputs, minimum one clock
// R4 - RX boost when level above urgent threshold
// R5 - RX request above threshold or finished nonempty
// R6 - TX boost when level at most urgent threshold
// R7 - TX request when level at most threshold
// R8 - Software polls, writes, reads, then clears active
// R9 - Done interrupt fires as soon as active
// R10 - On done interrupt write sixteen or finish
// R11 - On RX interrupt read twelve, write twelve
// R12 - DMA channels use 32-bit transfers
// R13 - Two DMA channels, DMA mode set first
// R14 - First DMA word carries length and settings
// R15 - Read channel completion ends the transfer
// R16 - One byte received per byte sent
// R17 - Clock toggles only while shifting a byte
// R18 - Select leads first msb by three clocks
// R19 - Select releases a clock after last edge
// R20 - Software may drive select when margins short
// R21 - First data write while idle loads settings
// R22 - Auto release drops select at count end
// R23 - Requests and boosts recomputed every cycle
module spi_master_dma #(
    parameter int FIFO_DEPTH = 64,
    parameter int LW = $clog2(FIFO_DEPTH)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic sclk,
    output logic mosi,
    input wire logic miso,
    output logic [2:0] chip_select_n,
    output logic irq,
    output logic tx_dma_request,
    output logic tx_priority_boost,
    output logic rx_dma_request,
    output logic rx_priority_boost
);
    localparam logic [LW:0] RX_NEEDS_LEVEL = (LW+1)'(FIFO_DEPTH * 3 / 4);

    // Control fields
    logic [1:0] chip_sel;
    logic sample_phase;
    logic idle_level;
    logic ta;
    logic dma_en;
    logic irq_done;
    logic irq_rx;
    logic auto_rel;
    logic low_speed;
    logic [15:0] clock_div;
    logic [15:0] dma_byte_count;
    logic [3:0] output_hold_delay;
    logic [31:0] dma_threshold_control;
    logic [15:0] remaining;
    logic [1:0] cs_age;
    logic [1:0] lane;
    logic [23:0] rd_word;
    logic miso_meta;
    logic miso_sync;

    // Bus decode
    logic acc;
    logic wr_ctrl;
    logic data_acc;
    logic dma_word;
    logic step;
    logic cfg_word_wr;
    logic mapped;
    logic done;
    logic dma_finished;
    logic rx_needs;
    logic shift_start;
    logic auto_release;
    spi_master_pkg::byte_t cur_byte;

    // FIFO ports
    logic tx_clear;
    logic rx_clear;
    logic tx_push;
    logic tx_pop;
    logic rx_pop;
    spi_master_pkg::byte_t tx_wdata;
    spi_master_pkg::byte_t tx_rdata;
    spi_master_pkg::byte_t rx_rdata;
    logic [LW:0] tx_level;
    logic [LW:0] rx_level;
    logic tx_full;
    logic tx_empty;
    logic rx_full;
    logic rx_empty;

    spi_byte_if link_bus();

    assign acc = psel && penable;
    assign wr_ctrl = acc && pwrite && paddr == `OFS_CONTROL;
    assign data_acc = acc && paddr == `OFS_DATA;
    assign mapped = paddr == `OFS_CONTROL || paddr == `OFS_DATA || paddr == `OFS_CLOCK_DIV
        || paddr == `OFS_BYTE_COUNT || paddr == `OFS_HOLD || paddr == `OFS_THRESH;
    // DMA data words move one byte per cycle; the bus waits meanwhile
    // Reads stay word-wide after auto release so the read channel can drain RX
    assign dma_word = data_acc && dma_en && (ta || !pwrite);
    assign step = dma_word && (pwrite ? !tx_full : (!rx_empty || !ta || dma_finished));
    assign pready = dma_word ? (step && lane == `LAST_LANE) : 1'b1;
    assign pslverr = acc && !mapped;
    assign cfg_word_wr = data_acc && pwrite && !ta; // [R21]

    // Done reads zero while idle; in DMA mode it waits for the count
    assign done = ta && link_bus.idle && (dma_en ? remaining == 16'h0000 : tx_empty);
    assign dma_finished = link_bus.idle && remaining == 16'h0000;
    assign rx_needs = ta && rx_level >= RX_NEEDS_LEVEL;
    assign irq = ta && ((irq_done && done) || (irq_rx && rx_needs)); // [R9]

    // Byte start waits for select setup, a byte to send and RX room
    assign shift_start = ta && cs_age == `CS_SETUP_CYCLES && link_bus.idle && !tx_empty
        && !rx_full && (!dma_en || remaining != 16'h0000); // [R2] [R17] [R18]
    assign auto_release = ta && dma_en && auto_rel && remaining == 16'h0000
        && link_bus.idle && !tx_pop; // [R22]

    // FIFO traffic
    assign tx_wdata = dma_word ? 8'(pwdata >> {lane, 3'b000}) : pwdata[7:0];
    assign tx_push = (data_acc && pwrite && ta && !dma_en) || (step && pwrite);
    assign tx_pop = shift_start;
    assign rx_pop = (data_acc && !pwrite && !dma_en) || (step && !pwrite);
    assign tx_clear = (wr_ctrl && pwdata[`B_CLEAR_TX]) || auto_release;
    assign rx_clear = wr_ctrl && pwdata[`B_CLEAR_RX];
    assign cur_byte = rx_empty ? 8'h00 : rx_rdata;

    // Request and boost levels follow the FIFOs each cycle
    assign rx_priority_boost = dma_en
        && 8'(rx_level) > dma_threshold_control[`F_RX_URGENT]; // [R4] [R23]
    assign rx_dma_request = dma_en && (8'(rx_level) > dma_threshold_control[`F_RX_REQ]
        || (dma_finished && !rx_empty)); // [R5] [R23]
    assign tx_priority_boost = dma_en
        && 8'(tx_level) <= dma_threshold_control[`F_TX_URGENT]; // [R6] [R23]
    assign tx_dma_request = dma_en
        && 8'(tx_level) <= dma_threshold_control[`F_TX_REQ]; // [R7] [R23]

    // Select lines, one per decoded code; code three selects none
    genvar gi;
    for (gi = 0; gi < 3; gi++) begin : g_select
        assign chip_select_n[gi] = !(ta && chip_sel == 2'(gi));
    end

    // Engine hookup
    assign link_bus.start = shift_start;
    assign link_bus.tx_byte = tx_rdata;
    assign link_bus.idle_level = idle_level;
    assign link_bus.sample_phase = sample_phase;
    assign link_bus.low_speed = low_speed;
    assign link_bus.hold = output_hold_delay;
    // Zero divides by 65536; one divides by two; other odd divisors round down
    assign link_bus.half_period = (clock_div == 16'h0000) ? `HALF_AT_ZERO
        : (clock_div[15:1] == 15'h0000) ? 16'h0001 : {1'b0, clock_div[15:1]};

    // Read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (acc && !pwrite) begin
            case (paddr)
                `OFS_CONTROL: begin
                    prdata[`B_CHIP_SEL] = chip_sel;
                    prdata[`B_PHASE] = sample_phase;
                    prdata[`B_IDLE_LEVEL] = idle_level;
                    prdata[`B_ACTIVE] = ta;
                    prdata[`B_DMA_EN] = dma_en;
                    prdata[`B_IRQ_DONE] = irq_done;
                    prdata[`B_IRQ_RX] = irq_rx;
                    prdata[`B_AUTO_REL] = auto_rel;
                    prdata[`B_LOW_SPEED] = low_speed;
                    prdata[`B_DONE] = done;
                    prdata[`B_RX_NEEDS] = rx_needs;
                    prdata[`B_TX_SPACE] = !tx_full;
                    prdata[`B_RX_DATA] = !rx_empty;
                    prdata[`B_RX_FULL] = rx_full;
                end
                `OFS_DATA: prdata = dma_word ? {cur_byte, rd_word} : {24'h00_0000, cur_byte};
                `OFS_CLOCK_DIV: prdata[`F_COUNT] = clock_div;
                `OFS_BYTE_COUNT: prdata[`F_COUNT] = dma_byte_count;
                `OFS_HOLD: prdata[`F_HOLD] = output_hold_delay;
                `OFS_THRESH: prdata = dma_threshold_control;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // Control register; an idle data-port write sets the low settings byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {chip_sel, sample_phase, idle_level, ta} <= 5'h00;
            {dma_en, irq_done, irq_rx, auto_rel, low_speed} <= 5'h00;
        end else if (wr_ctrl) begin
            chip_sel <= pwdata[`B_CHIP_SEL];
            sample_phase <= pwdata[`B_PHASE];
            idle_level <= pwdata[`B_IDLE_LEVEL];
            ta <= pwdata[`B_ACTIVE];
            dma_en <= pwdata[`B_DMA_EN];
            irq_done <= pwdata[`B_IRQ_DONE];
            irq_rx <= pwdata[`B_IRQ_RX];
            auto_rel <= pwdata[`B_AUTO_REL];
            low_speed <= pwdata[`B_LOW_SPEED];
        end else if (cfg_word_wr) begin
            chip_sel <= pwdata[`B_CHIP_SEL]; // [R21]
            sample_phase <= pwdata[`B_PHASE];
            idle_level <= pwdata[`B_IDLE_LEVEL];
            ta <= pwdata[`B_ACTIVE];
        end else if (auto_release) begin
            ta <= 1'b0; // [R22]
        end
    end

    // Plain configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_div <= 16'h0000;
            output_hold_delay <= `RST_HOLD; // [R3]
            dma_threshold_control <= {`RST_RX_URGENT, `RST_RX_REQ, `RST_TX_URGENT, `RST_TX_REQ};
        end else if (acc && pwrite) begin
            if (paddr == `OFS_CLOCK_DIV) clock_div <= pwdata[`F_COUNT];
            if (paddr == `OFS_HOLD) output_hold_delay <= pwdata[`F_HOLD];
            if (paddr == `OFS_THRESH) dma_threshold_control <= pwdata;
        end
    end

    // Byte count and the live remainder of a DMA transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_byte_count <= 16'h0000;
            remaining <= 16'h0000;
        end else if (cfg_word_wr && dma_en) begin
            dma_byte_count <= pwdata[`F_WORD_COUNT]; // [R1] [R21]
            remaining <= pwdata[`F_WORD_COUNT];
        end else if (acc && pwrite && paddr == `OFS_BYTE_COUNT) begin
            dma_byte_count <= pwdata[`F_COUNT]; // [R1]
            remaining <= pwdata[`F_COUNT];
        end else if (shift_start && dma_en) begin
            remaining <= remaining - 16'h0001; // [R2]
        end
    end

    // Select setup age, restarted whenever the transfer is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cs_age <= 2'h0;
        else if (!ta) cs_age <= 2'h0;
        else if (cs_age != `CS_SETUP_CYCLES) cs_age <= cs_age + 2'h1; // [R18]
    end

    // Word lane and gathered read bytes, low byte first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane <= 2'h0;
            rd_word <= 24'h00_0000;
        end else if (step) begin
            lane <= lane + 2'h1;
            if (lane != `LAST_LANE) rd_word <= 24'(({8'h00, cur_byte} << {lane, 3'b000})
                | (lane == 2'h0 ? 32'h0000_0000 : {8'h00, rd_word}));
        end
    end

    // Serial input crosses in through two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_meta <= 1'b0;
            miso_sync <= 1'b0;
        end else begin
            miso_meta <= miso;
            miso_sync <= miso_meta;
        end
    end

    spi_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .pclk(pclk), .presetn(presetn), .clear(tx_clear), .push(tx_push),
        .wdata(tx_wdata), .pop(tx_pop), .rdata(tx_rdata), .level(tx_level),
        .full(tx_full), .empty(tx_empty));

    spi_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .pclk(pclk), .presetn(presetn), .clear(rx_clear), .push(link_bus.rx_valid),
        .wdata(link_bus.rx_byte), .pop(rx_pop), .rdata(rx_rdata), .level(rx_level),
        .full(rx_full), .empty(rx_empty));

    spi_shifter u_shifter (
        .pclk(pclk), .presetn(presetn), .bus(link_bus.eng), .miso(miso_sync),
        .sclk(sclk), .mosi(mosi));

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_COUNT_LOAD: assert property ( // [R1]
        cfg_word_wr && dma_en |=> dma_byte_count == $past(pwdata[`F_WORD_COUNT])
        && ta == $past(pwdata[`B_ACTIVE]))
        else $error("first DMA word did not load count and settings");
    AST_COUNT_POLL: assert property ( // [R2]
        shift_start && !dma_en && !wr_ctrl && !data_acc && paddr != `OFS_BYTE_COUNT
        |=> $stable(remaining))
        else $error("byte count moved in polled mode");
    AST_RX_BOOST: assert property ( // [R4]
        dma_en && 32'(rx_level) > 32'(dma_threshold_control[`F_RX_URGENT]) |-> rx_priority_boost)
        else $error("RX boost missing");
    AST_RX_TAIL: assert property ( // [R5]
        dma_en && done && !rx_empty |-> rx_dma_request)
        else $error("RX request missing after finish");
    AST_TX_LEVELS: assert property ( // [R6]
        dma_en && tx_empty |-> tx_priority_boost && tx_dma_request)
        else $error("TX request or boost missing when empty");
    AST_DONE_IRQ: assert property ( // [R9]
        $rose(ta) && irq_done && !dma_en && tx_empty && link_bus.idle |-> irq)
        else $error("no interrupt when transfer started");
    AST_CS_SETUP: assert property ( // [R18]
        shift_start |-> $past(ta) && $past(ta, 2) && $past(ta, 3))
        else $error("select setup shorter than three clocks");
    AST_CS_RELEASE: assert property ( // [R19]
        $fell(ta) && $past(auto_rel) |-> $past(link_bus.idle))
        else $error("select released too soon after last edge");
    AST_AUTO_REL: assert property ( // [R22]
        auto_release && !wr_ctrl |=> !ta ##1 chip_select_n == 3'h7)
        else $error("auto release did not drop select");
    COV_DMA_RUN: cover property (dma_en && auto_rel ##1 auto_release);
    COV_POLL_BYTE: cover property (!dma_en && shift_start ##[1:600] link_bus.rx_valid);
    COV_DMA_READ: cover property (dma_word && !pwrite && pready);
endmodule

// ### core/spi_master_pkg.sv
package spi_master_pkg;
    typedef enum logic [1:0] {sh_idle, sh_run, sh_tail} shift_state_t;
    typedef logic [7:0] byte_t;
endpackage

// ### core/spi_shifter.sv
`timescale 1ns/1ps
`include "spi_master_defs.svh"
module spi_shifter (
    input wire logic pclk,
    input wire logic presetn,
    spi_byte_if.eng bus,
    input wire logic miso,
    output logic sclk,
    output logic mosi
);
    spi_master_pkg::shift_state_t state;
    logic [15:0] div_cnt;
    logic tick;
    logic [3:0] edge_no;
    spi_master_pkg::byte_t tx_sh;
    spi_master_pkg::byte_t rx_sh;
    logic pend_bit;
    logic [3:0] hold_cnt;
    logic sample;
    logic present;
    logic load;
    logic [3:0] in_flight;

    assign load = (state == spi_master_pkg::sh_idle) && bus.start;
    assign tick = (state != spi_master_pkg::sh_idle)
        && (div_cnt == bus.half_period - 16'h0001);
    assign sample = (state == spi_master_pkg::sh_run) && tick
        && (edge_no[0] == bus.sample_phase);
    // Phase 0 shows the msb at load, phase 1 on the first edge
    assign present = (load && !bus.sample_phase) || ((state == spi_master_pkg::sh_run) && tick
        && (edge_no[0] != bus.sample_phase) && (edge_no != `LAST_EDGE));
    assign bus.idle = state == spi_master_pkg::sh_idle;
    assign bus.rx_byte = rx_sh;

    // Half-period divider, restarted per byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_cnt <= 16'h0000;
        else if (state == spi_master_pkg::sh_idle || tick) div_cnt <= 16'h0000;
        else div_cnt <= div_cnt + 16'h0001;
    end

    // Byte sequencer; tail keeps a half period after the last edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= spi_master_pkg::sh_idle;
            edge_no <= 4'h0;
            bus.rx_valid <= 1'b0;
        end else begin
            bus.rx_valid <= 1'b0;
            unique case (state)
                spi_master_pkg::sh_idle: begin
                    edge_no <= 4'h0;
                    if (bus.start) state <= spi_master_pkg::sh_run;
                end
                spi_master_pkg::sh_run: if (tick) begin
                    edge_no <= edge_no + 4'h1;
                    if (edge_no == `LAST_EDGE) state <= spi_master_pkg::sh_tail; // [R19]
                end
                spi_master_pkg::sh_tail: if (tick) begin
                    state <= spi_master_pkg::sh_idle;
                    bus.rx_valid <= 1'b1; // [R16]
                end
            endcase
        end
    end

    // Clock toggles only inside a byte, else rests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sclk <= 1'b0;
        else if (state == spi_master_pkg::sh_idle) sclk <= bus.idle_level; // [R17]
        else if (state == spi_master_pkg::sh_run && tick) sclk <= ~sclk;
    end

    // Shift out and in; one byte in for every byte out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sh <= 8'h00;
            rx_sh <= 8'h00;
        end else begin
            if (load) tx_sh <= bus.sample_phase ? bus.tx_byte : {bus.tx_byte[6:0], 1'b0};
            else if (present) tx_sh <= {tx_sh[6:0], 1'b0};
            if (sample) rx_sh <= {rx_sh[6:0], miso}; // [R16]
        end
    end

    // Data line; low-speed link delays each change by the hold count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mosi <= 1'b0;
            pend_bit <= 1'b0;
            hold_cnt <= 4'h0;
        end else if (present && bus.low_speed) begin
            pend_bit <= load ? bus.tx_byte[7] : tx_sh[7];
            hold_cnt <= (bus.hold == 4'h0) ? 4'h1 : bus.hold; // [R3]
        end else if (present) begin
            mosi <= load ? bus.tx_byte[7] : tx_sh[7];
        end else if (hold_cnt != 4'h0) begin
            hold_cnt <= hold_cnt - 4'h1;
            if (hold_cnt == 4'h1) mosi <= pend_bit;
        end
    end

    // Checker helper: bytes started but not yet returned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) in_flight <= 4'h0;
        else if (load && !bus.rx_valid) in_flight <= in_flight + 4'h1;
        else if (bus.rx_valid && !load) in_flight <= in_flight - 4'h1;
    end

    AST_HOLD_OUTPUT: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        present && bus.low_speed |=> $stable(mosi))
        else $error("data line changed with no hold");
    AST_BYTE_PAIRING: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
        bus.idle |-> in_flight == {3'h0, bus.rx_valid})
        else $error("sent byte without received byte");
    AST_CLOCK_REST: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
        bus.idle && $past(bus.idle) && $stable(bus.idle_level) |-> sclk == bus.idle_level)
        else $error("serial clock not at rest level");
    COV_HOLD: cover property (@(posedge pclk) disable iff (!presetn)
        present && bus.low_speed ##1 hold_cnt == 4'h1);
endmodule

// ### dv/spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model #(
    parameter logic [7:0] REPLY = 8'h3c
) (
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] sr = 8'h00;
    logic last = 1'b0;
    // Reply loaded as select falls
    always @(negedge sel_n) sr = REPLY;
    // Mode 0: sample on rise, msb first
    always @(posedge sclk) if (!sel_n) got <= {got[6:0], mosi};
    // Rotate so every byte answers the same reply
    always @(negedge sclk) if (!sel_n) sr <= {sr[6:0], sr[7]};
    // Released line shows the inverse, never a stale copy
    always @* begin
        if (!sel_n) begin
            miso = sr[7];
            last = sr[7];
        end else begin
            miso = ~last;
        end
    end
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
`include "spi_master_defs.svh"
module tb;
    logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, sclk, mosi, miso;
    logic irq, txr, txb, rx_needs_reading, rxb;
    logic [7:0] paddr = 8'h00, got;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [2:0] chip_select_n;
    int err_count = 0, total_checks = 0, cyc = 0, i;
    spi_master_dma spi_master_dma_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk(sclk), .mosi(mosi), .miso(miso),
        .chip_select_n(chip_select_n), .irq(irq), .tx_dma_request(txr),
        .tx_priority_boost(txb), .rx_dma_request(rx_needs_reading), .rx_priority_boost(rxb));
    spi_slave_model spi_slave_model_i (.sel_n(chip_select_n[0]), .sclk(sclk), .mosi(mosi),
        .miso(miso), .got(got));
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            print_verdict;
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask
    // One APB transfer; answer taken at the edge where pready is high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        q[31] = (a == 8'h40) ? pslverr : q[31];
        psel <= 0;
        penable <= 0;
        // One idle edge so no strobe is driven twice in a time step
        @(posedge pclk);
    endtask
    task test_regs;
        apb(0, `OFS_BYTE_COUNT, 0); chk("byte_count", 0, q);
        apb(0, `OFS_HOLD, 0); chk("hold", 1, q[3:0]);
        apb(0, `OFS_THRESH, 0); chk("thresholds", 32'h30201020, q);
        apb(1, `OFS_HOLD, 0); apb(0, `OFS_HOLD, 0); chk("hold rw", 0, q[3:0]);
        apb(0, 8'h40, 0); chk("unmapped", 32'h80000000, q);
    endtask
    task test_polled;
        apb(1, `OFS_BYTE_COUNT, 1);
        apb(1, `OFS_CLOCK_DIV, 8);
        apb(1, `OFS_CONTROL, 32'h00000280);
        @(posedge pclk);
        chk("irq", 1, irq);
        chk("select", 3'b110, chip_select_n);
        apb(1, `OFS_DATA, 32'ha5);
        apb(1, `OFS_DATA, 32'h5a);
        for (i = 0; i < 1000; i++) begin
            apb(0, `OFS_CONTROL, 0);
            if (q[16] === 1'b1) break;
        end
        chk("done", 1, q[16]);
        apb(0, `OFS_DATA, 0); chk("rx0", 32'h3c, q);
        apb(0, `OFS_DATA, 0); chk("rx1", 32'h3c, q);
        chk("sent", 8'h5a, got);
        apb(1, `OFS_CONTROL, 0);
        @(posedge pclk);
        chk("deselect", 3'b111, chip_select_n);
    endtask
    // RX level interrupt: fill to the mark, then read one burst of twelve
    task test_rx_irq;
        apb(1, `OFS_CONTROL, 32'h00000480);
        for (i = 0; i < 48; i++) apb(1, `OFS_DATA, 32'h0f);
        for (i = 0; i < 6000 && irq !== 1'b1; i++) @(posedge pclk);
        chk("rx level irq", 1, irq);
        for (i = 0; i < 12; i++) begin
            apb(0, `OFS_DATA, 0);
            chk("rx burst", 32'h3c, q);
        end
        apb(0, `OFS_CONTROL, 0); chk("rx needs cleared", 0, q[`B_RX_NEEDS]);
        chk("irq cleared", 0, irq);
        chk("burst sent", 8'h0f, got);
        apb(1, `OFS_CONTROL, 32'h00000020);
    endtask
    // Low-speed link with a hold shorter than the half period
    task test_low_speed;
        apb(1, `OFS_HOLD, 3);
        apb(1, `OFS_CONTROL, 32'h00002080);
        apb(1, `OFS_DATA, 32'hc3);
        for (i = 0; i < 1000 && q[`B_DONE] !== 1'b1; i++) apb(0, `OFS_CONTROL, 0);
        chk("low speed done", 1, q[`B_DONE]);
        chk("low speed sent", 8'hc3, got);
        apb(0, `OFS_DATA, 0); chk("low speed rx", 32'h3c, q);
        apb(1, `OFS_CONTROL, 0);
    endtask
    task test_dma;
        apb(1, `OFS_CONTROL, 32'h00000900);
        @(posedge pclk);
        chk("tx req", 1, txr);
        chk("tx boost", 1, txb);
        chk("rx req", 0, rx_needs_reading);
        chk("rx boost", 0, rxb);
        apb(1, `OFS_DATA, 32'h00010080);
        apb(0, `OFS_BYTE_COUNT, 0); chk("loaded count", 1, q[15:0]);
        apb(1, `OFS_DATA, 32'h000000a5);
        for (i = 0; i < 3000 && chip_select_n !== 3'b111; i++) @(posedge pclk);
        chk("auto release", 3'b111, chip_select_n);
        chk("dma sent", 8'ha5, got);
        apb(0, `OFS_CONTROL, 0); chk("active", 0, q[7]);
        chk("rx tail req", 1, rx_needs_reading);
        apb(0, `OFS_DATA, 0); chk("dma word read", 32'h3c, q);
        chk("rx drained", 0, rx_needs_reading);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        test_regs;
        test_polled;
        test_rx_irq;
        test_low_speed;
        test_dma;
        print_verdict;
    end
endmodule
